// ### clock_power_down_reset_control.sv
`timescale 1ns/1ns
`default_nettype none
`include "clock_params.svh"
module clock_power_down_reset_control import clock_pkg::*; #(
    parameter bit LARGE_VARIANT = 1'b0,
    parameter int CLK_RATE_KHZ = `CLK_RATE_KHZ,
    parameter int RC_OSC_RATE_KHZ = `RC_OSC_RATE_KHZ,
    parameter int WDT_OSC_RATE_KHZ = `WDT_OSC_RATE_KHZ
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic oscillator_input,
    output logic oscillator_output,
    input wire logic master_clear_input_n,
    input wire logic brownout_detect,
    input wire logic program_mode,
    input wire logic sleep_instruction,
    input wire logic wakeup_pin_event,
    input wire logic watchdog_timeout,
    output logic instruction_tick,
    output logic operating_clock_tick,
    output logic watchdog_tick,
    output logic core_reset,
    output logic [11:0] reset_vector,
    output logic timeout_flag,
    output logic power_down_flag,
    output logic powered_down
);
    localparam int RC_BASE_DIV = CLK_RATE_KHZ / RC_OSC_RATE_KHZ;
    localparam int WDT_BASE_DIV = CLK_RATE_KHZ / WDT_OSC_RATE_KHZ;
    localparam logic [11:0] VECTOR = LARGE_VARIANT ? `VECTOR_LARGE : `VECTOR_SMALL;

    generate
        if (RC_BASE_DIV < 1 || RC_BASE_DIV > 256) begin : g_bad_rc
            $error("Clock rate cannot serve the internal RC rate");
        end
        if (WDT_BASE_DIV < 1 || WDT_BASE_DIV > 65536) begin : g_bad_wdt
            $error("Clock rate cannot serve the watchdog oscillator rate");
        end
    endgenerate

    // Pins from outside the clock domain
    logic osc_s;
    logic master_clear_input_n_n_s;
    logic brown_s;
    logic prog_s;

    sync2 #(
        .WIDTH(4),
        .RESET_VALUE(4'h4)
    ) u_pin_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in({brownout_detect, master_clear_input_n, program_mode, oscillator_input}),
        .sync_out({brown_s, master_clear_input_n_n_s, prog_s, osc_s})
    );

    // Bus slave state
    logic sel_r;
    logic sel_nxt;
    logic wr_r;
    logic wr_nxt;
    logic [11:0] addr_r;
    logic [11:0] addr_nxt;
    logic [31:0] hrdata_r;
    logic [31:0] hrdata_nxt;
    logic [`CONFIG_WIDTH-1:0] config_r;
    logic [`CONFIG_WIDTH-1:0] config_nxt;
    logic [`CONFIG_WIDTH-1:0] ext_config_r;
    logic [`CONFIG_WIDTH-1:0] ext_config_nxt;
    logic hreadyout_r;

    // Clock path state
    logic osc_prev_r;
    logic [1:0] quarter_r;
    logic [1:0] quarter_nxt;
    logic inst_tick_r;
    logic inst_tick_nxt;
    logic op_tick_r;
    logic op_tick_nxt;
    logic osc_out_r;
    logic osc_out_nxt;

    // Power state
    power_state_t state_r;
    power_state_t state_nxt;
    logic core_reset_r;
    logic core_reset_nxt;
    logic asleep_r;
    logic asleep_nxt;
    logic to_r;
    logic to_nxt;
    logic pd_r;
    logic pd_nxt;
    logic [11:0] vector_r;

    // Decoded configuration
    logic [1:0] div_sel;
    osc_mode_t osc_mode;
    logic turbo;
    logic wdt_en;
    logic sleep_clk_en;
    logic [7:0] rc_div_m1;
    logic rc_base_tick;
    logic rc_clk_tick;
    logic ext_tick;
    logic osc_tick;
    logic crystal_mode;
    logic running;
    logic reset_cause;
    logic addr_phase;
    logic [31:0] status_word;

    assign div_sel = config_r[`CFG_DIV_LSB +: 2];
    assign osc_mode = osc_mode_t'(config_r[`CFG_MODE_LSB +: 3]);
    // Compatible mode exists on the small variant only
    assign turbo = config_r[`CFG_TURBO_BIT] | LARGE_VARIANT;
    assign wdt_en = config_r[`CFG_WDT_EN_BIT];
    assign sleep_clk_en = ext_config_r[`XCFG_SLEEP_CLK_BIT] & LARGE_VARIANT;
    // Any code from two upward is a crystal-class mode
    assign crystal_mode = (osc_mode != MODE_INT_RC) && (osc_mode != MODE_EXT_RC);

    always_comb begin
        unique case (div_sel)
            2'h0: rc_div_m1 = `RC_DIV_M1_SEL0;
            2'h1: rc_div_m1 = `RC_DIV_M1_SEL1;
            2'h2: rc_div_m1 = `RC_DIV_M1_SEL2;
            2'h3: rc_div_m1 = `RC_DIV_M1_SEL3;
        endcase
    end

    // Internal RC modelled as a nominal-rate enable, then the selectable divider
    tick_divider #(
        .WIDTH(8)
    ) u_rc_base (
        .hclk(hclk),
        .hresetn(hresetn),
        .count_en(1'b1),
        .divide_m1(8'(RC_BASE_DIV - 1)),
        .tick(rc_base_tick)
    );

    tick_divider #(
        .WIDTH(8)
    ) u_rc_div (
        .hclk(hclk),
        .hresetn(hresetn),
        .count_en(rc_base_tick),
        .divide_m1(rc_div_m1),
        .tick(rc_clk_tick)
    );

    // Watchdog oscillator never looks at the power state
    tick_divider #(
        .WIDTH(16)
    ) u_wdt_osc (
        .hclk(hclk),
        .hresetn(hresetn),
        .count_en(wdt_en),
        .divide_m1(16'(WDT_BASE_DIV - 1)),
        .tick(watchdog_tick)
    );

    // Pin is sampled, so external clocks must stay below half of hclk
    assign ext_tick = osc_s & ~osc_prev_r;
    assign osc_tick = (osc_mode == MODE_INT_RC) ? rc_clk_tick : ext_tick;
    assign running = (state_r == ST_RUN);

    always_comb begin
        quarter_nxt = quarter_r;
        inst_tick_nxt = 1'b0;
        op_tick_nxt = 1'b0;
        osc_out_nxt = 1'b0;
        if (osc_tick) begin
            quarter_nxt = quarter_r + 2'h1;
        end
        // Gating acts on whole enable pulses, so no sliver of a clock escapes
        if (running) begin
            if (turbo) begin
                inst_tick_nxt = osc_tick;
            end else begin
                inst_tick_nxt = osc_tick && (quarter_r == `QUARTER_LAST);
            end
        end
        op_tick_nxt = osc_tick & (running | sleep_clk_en);
        if (crystal_mode) begin
            osc_out_nxt = ~osc_s;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_prev_r <= 1'b0;
            quarter_r <= 2'h0;
            inst_tick_r <= 1'b0;
            op_tick_r <= 1'b0;
            osc_out_r <= 1'b0;
        end else begin
            osc_prev_r <= osc_s;
            quarter_r <= quarter_nxt;
            inst_tick_r <= inst_tick_nxt;
            op_tick_r <= op_tick_nxt;
            osc_out_r <= osc_out_nxt;
        end
    end

    // Power-down, wakeup and reset sequencing
    assign reset_cause = ~master_clear_input_n_n_s | brown_s | watchdog_timeout;

    always_comb begin
        state_nxt = state_r;
        to_nxt = to_r;
        pd_nxt = pd_r;
        unique case (state_r)
            ST_RUN: begin
                if (reset_cause) begin
                    state_nxt = ST_WAKE;
                end else if (sleep_instruction) begin
                    state_nxt = ST_SLEEP;
                    if (wdt_en) begin
                        to_nxt = 1'b1;
                        pd_nxt = 1'b0;
                    end
                end
            end
            ST_SLEEP: begin
                if (reset_cause || wakeup_pin_event) begin
                    state_nxt = ST_WAKE;
                    to_nxt = 1'b1;
                    pd_nxt = 1'b1;
                end
            end
            ST_WAKE: begin
                // Held while master clear or brown-out persists
                if (!(~master_clear_input_n_n_s | brown_s)) begin
                    state_nxt = ST_RUN;
                end
            end
        endcase
        core_reset_nxt = (state_nxt == ST_WAKE);
        asleep_nxt = (state_nxt == ST_SLEEP);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= ST_RUN;
            core_reset_r <= 1'b1;
            asleep_r <= 1'b0;
            to_r <= 1'b1;
            pd_r <= 1'b1;
            vector_r <= VECTOR;
        end else begin
            state_r <= state_nxt;
            core_reset_r <= core_reset_nxt;
            asleep_r <= asleep_nxt;
            to_r <= to_nxt;
            pd_r <= pd_nxt;
            vector_r <= VECTOR;
        end
    end

    // AHB-Lite slave, zero wait states
    assign addr_phase = hsel & htrans[1] & hready;
    assign status_word = {26'h0, prog_s, state_r, pd_r, to_r};

    always_comb begin
        sel_nxt = addr_phase;
        wr_nxt = addr_phase & hwrite;
        addr_nxt = addr_phase ? haddr[11:0] : addr_r;
        hrdata_nxt = hrdata_r;
        config_nxt = config_r;
        ext_config_nxt = ext_config_r;
        if (addr_phase && !hwrite) begin
            unique case (haddr[11:0])
                `REG_CONFIG_ADDR: hrdata_nxt = {20'h0, config_r};
                `REG_EXT_CONFIG_ADDR: hrdata_nxt = {20'h0, ext_config_r};
                `REG_STATUS_ADDR: hrdata_nxt = status_word;
                default: hrdata_nxt = 32'h0;
            endcase
        end
        // Running code cannot alter the fuses; only the programming pin opens them
        if (sel_r && wr_r && prog_s) begin
            if (addr_r == `REG_CONFIG_ADDR) begin
                config_nxt = hwdata[`CONFIG_WIDTH-1:0];
            end
            if (addr_r == `REG_EXT_CONFIG_ADDR) begin
                ext_config_nxt = hwdata[`CONFIG_WIDTH-1:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_r <= 1'b0;
            wr_r <= 1'b0;
            addr_r <= 12'h000;
            hrdata_r <= 32'h0;
            config_r <= `CONFIG_RESET;
            ext_config_r <= `EXT_CONFIG_RESET;
            hreadyout_r <= 1'b1;
        end else begin
            sel_r <= sel_nxt;
            wr_r <= wr_nxt;
            addr_r <= addr_nxt;
            hrdata_r <= hrdata_nxt;
            config_r <= config_nxt;
            ext_config_r <= ext_config_nxt;
            hreadyout_r <= 1'b1;
        end
    end

    assign hrdata = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp = 1'b0;
    assign oscillator_output = osc_out_r;
    assign instruction_tick = inst_tick_r;
    assign operating_clock_tick = op_tick_r;
    assign core_reset = core_reset_r;
    assign reset_vector = vector_r;
    assign timeout_flag = to_r;
    assign power_down_flag = pd_r;
    // Registered copy, so the pin never glitches while the state code switches
    assign powered_down = asleep_r;

endmodule : clock_power_down_reset_control
`default_nettype wire

// ### clock_params.svh
// Behaviour
// - Compatible mode: one instruction per four clocks
// - Turbo mode: one instruction per clock
// - Internal RC 4 MHz, divided by two-bit field
// - Clock mode held in 12-bit configuration word
// - Configuration word writable only while programming
// - Power-down instruction enters power-down state
// - Power-down gates clock off to all blocks but the watchdog
// - Enabled watchdog keeps counting on own oscillator
// - Wakeup resets and loads top program address
// - Reset on power-up, wakeup, brown-out, watchdog, clear
// - Large variant: extended bit keeps operating clock running in power-down
// - External clock: any crystal mode behaves identically
// - External RC takes clock from oscillator input only
// - Power-down with watchdog: timeout 1, power-down 0
// - Wakeup sets timeout and power-down flags to 1
`ifndef CLOCK_PARAMS_SVH
`define CLOCK_PARAMS_SVH

`define CLK_RATE_KHZ 100000
`define RC_OSC_RATE_KHZ 4000
`define WDT_OSC_RATE_KHZ 1000

`define REG_CONFIG_ADDR 12'h000
`define REG_EXT_CONFIG_ADDR 12'h004
`define REG_STATUS_ADDR 12'h008

`define CONFIG_WIDTH 12
`define CONFIG_RESET 12'h000
`define EXT_CONFIG_RESET 12'h000
`define CFG_DIV_LSB 0
`define CFG_MODE_LSB 2
`define CFG_TURBO_BIT 5
`define CFG_WDT_EN_BIT 6
`define XCFG_SLEEP_CLK_BIT 0

`define RC_DIV_M1_SEL0 8'h00
`define RC_DIV_M1_SEL1 8'h03
`define RC_DIV_M1_SEL2 8'h0f
`define RC_DIV_M1_SEL3 8'h7f

`define QUARTER_LAST 2'h3
`define VECTOR_SMALL 12'h7ff
`define VECTOR_LARGE 12'hfff

`define ST_TO_BIT 0
`define ST_PD_BIT 1
`define ST_STATE_LSB 2
`define ST_PROG_BIT 5

`endif

// ### clock_pkg.sv
package clock_pkg;

    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_SLEEP = 3'b010,
        ST_WAKE = 3'b100
    } power_state_t;

    typedef enum logic [2:0] {
        MODE_INT_RC = 3'h0,
        MODE_EXT_RC = 3'h1,
        MODE_LOW_POWER_CRYSTAL = 3'h2,
        MODE_NORMAL_CRYSTAL = 3'h3,
        MODE_HIGH_SPEED_CRYSTAL = 3'h4
    } osc_mode_t;

endpackage : clock_pkg

// ### sync2.sv
`timescale 1ns/1ns
`default_nettype none
module sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_r <= RESET_VALUE;
            sync_r <= RESET_VALUE;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;
endmodule : sync2
`default_nettype wire

// ### tick_divider.sv
`timescale 1ns/1ns
`default_nettype none
module tick_divider #(
    parameter int WIDTH = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic count_en,
    input wire logic [WIDTH-1:0] divide_m1,
    output logic tick
);
    logic [WIDTH-1:0] count_r;
    logic [WIDTH-1:0] count_nxt;
    logic tick_r;
    logic tick_nxt;

    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("tick_divider needs WIDTH of at least 1");
        end
    endgenerate

    // Ratio change takes effect in the current count, wrapping at once if already past it
    always_comb begin
        count_nxt = count_r;
        tick_nxt = 1'b0;
        if (count_en) begin
            if (count_r >= divide_m1) begin
                count_nxt = '0;
                tick_nxt = 1'b1;
            end else begin
                count_nxt = count_r + 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_r <= '0;
            tick_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick = tick_r;
endmodule : tick_divider
`default_nettype wire

// ### clock_power_down_reset_control_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module clock_checker #(
    parameter bit LARGE_VARIANT = 1'b0
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic master_clear_input_n,
    input wire logic brownout_detect,
    input wire logic sleep_instruction,
    input wire logic watchdog_timeout,
    input wire logic instruction_tick,
    input wire logic operating_clock_tick,
    input wire logic core_reset,
    input wire logic [11:0] reset_vector,
    input wire logic timeout_flag,
    input wire logic power_down_flag,
    input wire logic powered_down
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sleep_entry_a:
    assert property (sleep_instruction && !powered_down && !core_reset && master_clear_input_n
        && !brownout_detect && !watchdog_timeout |=> powered_down) else $error("sleep not taken");
    gated_ticks_a:
    assert property (powered_down && $past(powered_down) |->
        !instruction_tick && (LARGE_VARIANT || !operating_clock_tick)) else $error("tick in sleep");
    flag_clear_a:
    assert property ($fell(power_down_flag) |-> $rose(powered_down) && timeout_flag)
        else $error("power-down flag cleared outside sleep entry");
    wake_reset_a:
    assert property ($fell(powered_down) |-> core_reset && timeout_flag && power_down_flag)
        else $error("wakeup without reset and flags");
    vector_fixed_a:
    assert property (reset_vector == (LARGE_VARIANT ? 12'hfff : 12'h7ff))
        else $error("wrong reset vector");
    clear_reset_a:
    assert property (!master_clear_input_n |-> ##[1:4] core_reset) else $error("no clear reset");
    brownout_reset_a:
    assert property (brownout_detect |-> ##[1:4] core_reset) else $error("no brownout reset");
    watchdog_reset_a:
    assert property (watchdog_timeout && !core_reset |-> ##[1:2] core_reset)
        else $error("no watchdog reset");
    tick_pulse_a:
    assert property (instruction_tick |=> !instruction_tick [*2]) else $error("tick too long");
    cover property ($rose(powered_down));
    cover property ($fell(powered_down));
    cover property ($rose(core_reset) && !powered_down);
endmodule : clock_checker
bind clock_power_down_reset_control clock_checker #(.LARGE_VARIANT(LARGE_VARIANT)) chk_i (
    .hclk(hclk), .hresetn(hresetn), .master_clear_input_n(master_clear_input_n),
    .brownout_detect(brownout_detect), .sleep_instruction(sleep_instruction),
    .watchdog_timeout(watchdog_timeout), .instruction_tick(instruction_tick),
    .operating_clock_tick(operating_clock_tick), .core_reset(core_reset),
    .reset_vector(reset_vector), .timeout_flag(timeout_flag),
    .power_down_flag(power_down_flag), .powered_down(powered_down));
`default_nettype wire

// ### osc_source.sv
`timescale 1ns/1ns
`default_nettype none
module osc_source #(
    parameter int HALF_NS = 50
) (
    input wire logic run,
    output logic osc
);
    // Stands low when stopped, so a frozen level never looks like a live clock
    initial osc = 1'b0;
    always begin
        #HALF_NS;
        osc = run ? ~osc : 1'b0;
    end
endmodule : osc_source
`default_nettype wire

// ### test_clock_power_down_reset_control.sv
`timescale 1ns/1ns
`default_nettype none
`include "clock_params.svh"
module test_clock_power_down_reset_control;
    localparam int RC_GAP = `CLK_RATE_KHZ / `RC_OSC_RATE_KHZ;
    localparam int WDT_GAP = `CLK_RATE_KHZ / `WDT_OSC_RATE_KHZ;
    localparam int OSC_HALF = 50;
    localparam int OSC_GAP = 2 * OSC_HALF / 10;
    localparam int DV[4] = '{1, 4, 16, 128};
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, osc_in, osc_out, itick, otick, wtick, core_reset, to_f, pd_f, pdn;
    logic [11:0] rvec;
    logic master_clear_input_n_n = 1'b1;
    logic brownout = 1'b0;
    logic prog = 1'b0;
    logic sleep_i = 1'b0;
    logic wake_i = 1'b0;
    logic wdt_to = 1'b0;
    logic osc_run = 1'b0;
    int n_errors = 0;
    int checks = 0;
    osc_source #(.HALF_NS(OSC_HALF)) osc_i (.run(osc_run), .osc(osc_in));
    clock_power_down_reset_control dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .oscillator_input(osc_in), .oscillator_output(osc_out), .master_clear_input_n(master_clear_input_n_n),
        .brownout_detect(brownout), .program_mode(prog), .sleep_instruction(sleep_i),
        .wakeup_pin_event(wake_i), .watchdog_timeout(wdt_to), .instruction_tick(itick),
        .operating_clock_tick(otick), .watchdog_tick(wtick), .core_reset(core_reset),
        .reset_vector(rvec), .timeout_flag(to_f), .power_down_flag(pd_f), .powered_down(pdn));
    task summarize;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // Waits on hready rather than assuming the zero-wait answer
    task ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : ahb
    task cfg(input logic [31:0] a, input logic [31:0] v);
        logic [31:0] r;
        prog <= 1'b1;
        repeat (3) @(posedge hclk);
        ahb(1'b1, a, v, r);
        ahb(1'b0, a, 32'h0, r);
        chk("cfg", r, v);
        prog <= 1'b0;
        repeat (3) @(posedge hclk);
    endtask : cfg
    task gap(output int n);
        int k;
        k = 0;
        n = 0;
        do begin @(posedge hclk); k++; end while (itick !== 1'b1 && k < 10000);
        do begin @(posedge hclk); n++; end while (itick !== 1'b1 && n < 10000);
    endtask : gap
    task cnt(input int c, output int ni, output int nw, output int no);
        ni = 0;
        nw = 0;
        no = 0;
        repeat (c) begin
            @(posedge hclk);
            ni += int'(itick === 1'b1);
            nw += int'(wtick === 1'b1);
            no += int'(otick === 1'b1);
        end
    endtask : cnt
    task t_regs;
        logic [31:0] r;
        ahb(1'b0, 32'h0, 32'h0, r);
        chk("cfg_rst", r, 32'h0);
        chk("hresp", hresp, 1'b0);
        ahb(1'b1, 32'h0, 32'h7f, r);
        ahb(1'b0, 32'h0, 32'h0, r);
        chk("cfg_locked", r, 32'h0);
        ahb(1'b1, 32'h8, 32'h0, r);
        ahb(1'b0, 32'h8, 32'h0, r);
        chk("status", r, 32'h7);
        ahb(1'b0, 32'hc, 32'h0, r);
        chk("unmapped", r, 32'h0);
        cfg(32'h4, 32'h1);
    endtask : t_regs
    task t_rates;
        int n;
        for (int s = 0; s < 4; s++) begin
            cfg(32'h0, 32'h20 | 32'(s));
            gap(n);
            gap(n);
            chk("rc_gap", n, RC_GAP * DV[s]);
        end
        cfg(32'h0, 32'h0);
        gap(n);
        gap(n);
        chk("compat_gap", n, 4 * RC_GAP);
    endtask : t_rates
    // Every pin-driven mode code from 1 to 4, including the three named crystal modes, must clock alike
    task t_ext;
        int n, no, nh;
        osc_run <= 1'b1;
        for (int m = 1; m < 5; m++) begin
            cfg(32'h0, 32'h20 | (32'(m) << 2));
            gap(n);
            gap(n);
            chk("ext_gap", n, OSC_GAP);
            no = 0;
            nh = 0;
            repeat (2 * OSC_GAP) begin
                @(posedge hclk);
                no += int'(otick === 1'b1);
                nh += int'(osc_out === 1'b1);
            end
            chk("ext_otick", no, 2);
            chk("osc_out", nh, (m > 1) ? OSC_GAP : 0);
        end
        cfg(32'h0, 32'hc);
        gap(n);
        gap(n);
        chk("ext_compat", n, 4 * OSC_GAP);
        osc_run <= 1'b0;
    endtask : t_ext
    task t_sleep(input logic wd, input logic by_wdt);
        int ni, nw, no;
        logic [31:0] r;
        cfg(32'h0, wd ? 32'h60 : 32'h20);
        @(posedge hclk);
        sleep_i <= 1'b1;
        @(posedge hclk);
        sleep_i <= 1'b0;
        @(posedge hclk);
        chk("asleep", pdn, 1'b1);
        chk("flags_in", {to_f, pd_f}, {1'b1, !wd});
        cnt(300, ni, nw, no);
        chk("itick", ni, 0);
        chk("otick", no, 0);
        chk("wtick", nw, wd ? 300 / WDT_GAP : 0);
        ahb(1'b0, 32'h8, 32'h0, r);
        chk("st_sleep", r, wd ? 32'h9 : 32'hb);
        @(posedge hclk);
        wdt_to <= by_wdt;
        wake_i <= !by_wdt;
        @(posedge hclk);
        wdt_to <= 1'b0;
        wake_i <= 1'b0;
        @(posedge hclk);
        chk("wake_rst", {core_reset, pdn}, 2'b10);
        chk("flags_out", {to_f, pd_f}, 2'b11);
        @(posedge hclk);
        chk("run", core_reset, 1'b0);
        chk("vector", rvec, 12'h7ff);
    endtask : t_sleep
    task t_resets;
        logic s;
        for (int i = 0; i < 3; i++) begin
            @(posedge hclk);
            master_clear_input_n_n <= (i != 0);
            brownout <= (i == 1);
            wdt_to <= (i == 2);
            s = 1'b0;
            // A watchdog pulse resets for one cycle only, inside the hold window
            repeat (2) begin
                @(posedge hclk);
                s |= (core_reset === 1'b1);
            end
            master_clear_input_n_n <= 1'b1;
            brownout <= 1'b0;
            wdt_to <= 1'b0;
            repeat (6) begin @(posedge hclk); s |= (core_reset === 1'b1); end
            chk("cause_rst", s, 1'b1);
            repeat (6) @(posedge hclk);
            chk("released", core_reset, 1'b0);
        end
    endtask : t_resets
    initial begin
        forever #5 hclk = ~hclk;
    end
    initial begin
        #400000;
        n_errors++;
        summarize();
    end
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_rates();
        t_ext();
        t_sleep(1'b1, 1'b0);
        t_sleep(1'b1, 1'b1);
        t_sleep(1'b0, 1'b0);
        t_resets();
        summarize();
    end
endmodule : test_clock_power_down_reset_control
`default_nettype wire
